// ---- flash_bus_cycle.sv ----
`timescale 1ns/10ps
module flash_bus_cycle
    import flash_ctl_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        start,
    input  wire logic        wr,
    input  wire logic [17:0] addr,
    input  wire logic [15:0] wdata,
    output logic             done,
    output logic [15:0]      rdata,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic [17:0]      flash_addr,
    output logic [15:0]      flash_dq_o,
    output logic             flash_dq_oe_n,
    input  wire logic [15:0] flash_dq_i
);

    typedef struct packed {
        cyc_state_t  st;
        logic [5:0]  cnt;
        logic        wr;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        dq_oe_n;
        logic [17:0] a;
        logic [15:0] dout;
        logic [15:0] rd;
        logic        done;
        logic [15:0] s1;
        logic [15:0] s2;
    } cyc_t;

    localparam cyc_t CYC_RST = '{st: C_IDLE, cnt: 6'h00, wr: 1'b0,
        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1, a: RST_ADDR,
        dout: RST_DATA, rd: RST_DATA, done: 1'b0, s1: RST_DATA,
        s2: RST_DATA};

    cyc_t q;
    cyc_t d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.s1 = flash_dq_i;
        d.s2 = q.s1;
        case (q.st)
            C_IDLE: begin
                if (start) begin
                    d.a = addr;
                    d.dout = wdata;
                    d.wr = wr;
                    d.ce_n = 1'b0;
                    d.dq_oe_n = ~wr;
                    d.st = C_SETUP;
                end
            end
            C_SETUP: begin
                d.we_n = ~q.wr;
                d.oe_n = q.wr;
                d.cnt = q.wr ? CYC_WP : CYC_RD;
                d.st = C_STROBE;
            end
            C_STROBE: begin
                d.cnt = q.cnt - 6'h01;
                if (q.cnt == 6'h01) begin
                    d.we_n = 1'b1;
                    d.oe_n = 1'b1;
                    if (!q.wr) begin
                        d.rd = q.s2;
                    end
                    d.cnt = CYC_REC;
                    d.st = C_HOLD;
                end
            end
            C_HOLD: begin
                d.cnt = q.cnt - 6'h01;
                if (q.cnt == 6'h01) begin
                    d.ce_n = 1'b1;
                    d.dq_oe_n = 1'b1;
                    d.done = 1'b1;
                    d.st = C_IDLE;
                end
            end
            default: begin
                d = CYC_RST;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= CYC_RST;
        end else begin
            q <= d;
        end
    end

    assign done          = q.done;
    assign rdata         = q.rd;
    assign flash_ce_n    = q.ce_n;
    assign flash_oe_n    = q.oe_n;
    assign flash_we_n    = q.we_n;
    assign flash_addr    = q.a;
    assign flash_dq_o    = q.dout;
    assign flash_dq_oe_n = q.dq_oe_n;

endmodule // flash_bus_cycle

// ---- flash_ctl_pkg.sv ----
package flash_ctl_pkg;

    // flash command codes
    localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND     = 8'hb0;
    localparam logic [7:0] CMD_CLEAR       = 8'h50;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_ADDR  = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_STAT  = 8'h0c;
    localparam logic [7:0] OFS_RDATA = 8'h10;

    // control register fields
    localparam int CTRL_OP_LSB     = 0;
    localparam int CTRL_AUTOCLR    = 4;
    localparam int CTRL_RETARRAY   = 5;
    // software status register fields
    localparam int STAT_BUSY       = 0;
    localparam int STAT_DONE       = 1;
    localparam int STAT_FLASH_LSB  = 8;

    // operation status bits of the flash
    localparam int FS_READY        = 7;
    localparam int FS_SUSPENDED    = 6;
    localparam logic [7:0] FS_MASK = 8'hf8;

    // operations
    localparam logic [2:0] OP_READ    = 3'h0;
    localparam logic [2:0] OP_PROGRAM = 3'h1;
    localparam logic [2:0] OP_ERASE   = 3'h2;
    localparam logic [2:0] OP_SUSPEND = 3'h3;
    localparam logic [2:0] OP_RESUME  = 3'h4;
    localparam logic [2:0] OP_CLEAR   = 3'h5;
    localparam logic [2:0] OP_RSTAT   = 3'h6;
    localparam logic [2:0] OP_RARRAY  = 3'h7;

    // reset values
    localparam logic [17:0] RST_ADDR  = 18'h00000;
    localparam logic [15:0] RST_DATA  = 16'h0000;
    localparam logic [7:0]  RST_FSTAT = 8'h00;

    // pin timing
    localparam int CLK_NS      = 5;
    localparam int T_WP_NS     = 50;
    localparam int T_ACC_NS    = 150;
    localparam int T_REC_NS    = 20;
    localparam int SYNC_STAGES = 2;

    function automatic int ns_to_cyc(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    localparam logic [5:0] CYC_WP  = 6'(ns_to_cyc(T_WP_NS));
    localparam logic [5:0] CYC_RD  = 6'(ns_to_cyc(T_ACC_NS) + SYNC_STAGES);
    localparam logic [5:0] CYC_REC = 6'(ns_to_cyc(T_REC_NS));

    typedef enum logic [6:0] {
        S_IDLE  = 7'b0000001,
        S_CMD1  = 7'b0000010,
        S_CMD2  = 7'b0000100,
        S_POLL  = 7'b0001000,
        S_READ  = 7'b0010000,
        S_TAIL  = 7'b0100000,
        S_TAIL2 = 7'b1000000
    } seq_state_t;

    typedef enum logic [3:0] {
        C_IDLE   = 4'b0001,
        C_SETUP  = 4'b0010,
        C_STROBE = 4'b0100,
        C_HOLD   = 4'b1000
    } cyc_state_t;

endpackage

// ---- flash_model.sv ----
`timescale 1ns/10ps
module flash_model #(
    parameter int PROG_NS  = 600,
    parameter int ERASE_NS = 2000
) (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [17:0] addr,
    input  wire logic [15:0] dq_in,
    input  wire logic        vpp_ok,
    input  wire logic        fail_op,
    output logic [15:0]      dq_out
);
    logic [15:0] mem [0:255];
    logic [7:0]  stat = 8'h80;
    logic [7:0]  stat_l = 8'h80;
    logic [7:0]  prev = 8'hff;
    logic        rd_stat = 1'b0;
    logic        erasing = 1'b0;
    logic        susp = 1'b0;
    logic [15:0] junk = 16'h5a5a;
    int          left = 0;

    initial for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    // released bus keeps changing
    always #5 junk = ~junk;
    always @(negedge oe_n or negedge ce_n) stat_l = stat;
    assign dq_out = (!ce_n && !oe_n) ? (rd_stat ? {8'h00, stat_l}
                    : mem[addr[7:0]]) : junk;

    // sequencer timer, frozen while suspended
    always #10 if (left > 0 && !susp) begin
        left = left - 10;
        if (left <= 0) begin
            if (erasing) begin
                for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
                stat[5] = stat[5] | fail_op;
            end
            erasing = 1'b0;
            stat[7:6] = 2'b10;
        end
    end

    always @(posedge we_n) if (!ce_n) begin
        logic [7:0] c;
        logic       setup;
        c = dq_in[7:0];
        setup = 1'b0;
        if (prev == 8'h40 || prev == 8'h10) begin
            if (!vpp_ok) stat[3] = 1'b1;
            else begin
                mem[addr[7:0]] = mem[addr[7:0]] & dq_in;
                stat[4] = stat[4] | fail_op;
                stat[7] = 1'b0;
                left = PROG_NS;
            end
            rd_stat = 1'b1;
        end else if (prev == 8'h20) begin
            if (c != 8'hd0) stat = stat | 8'h30;
            else if (!vpp_ok) stat = stat | 8'h28;
            else begin
                erasing = 1'b1;
                stat[7] = 1'b0;
                left = ERASE_NS;
            end
            rd_stat = 1'b1;
        end else if (!stat[7]) begin
            if (c == 8'h70) rd_stat = 1'b1;
            if (c == 8'hb0 && erasing) begin
                stat[7:6] = 2'b11;
                susp = 1'b1;
            end
        end else begin
            setup = !susp && (c == 8'h40 || c == 8'h10 || c == 8'h20);
            case (c)
                8'hff: rd_stat = 1'b0;
                8'h70: rd_stat = 1'b1;
                8'h50: if (!susp) stat[5:3] = 3'b000;
                8'hd0: if (susp) begin
                    susp = 1'b0;
                    stat[7:6] = 2'b00;
                end
                default: ;
            endcase
        end
        prev = setup ? c : 8'hff;
    end
endmodule // flash_model

// ---- flash_program_erase_status.sv ----
// Notes on behaviour
// - host masks reserved status bits 2 to 0 when polling
// - host checks ready before trusting error bits
// - program is setup command then a write of address and data
// - after program or erase, read-array command needed before array reads
// - erase is 20h then d0h, block address latched at confirm
// - suspend pauses erase; host polls, then only read, status or resume
// - host resumes after reads; erase then completes
// - host clears status after each program or erase
// - after the last erase the host writes ffh to return to array
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
module flash_program_erase_status
    import flash_ctl_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic [17:0]      flash_addr,
    output logic [15:0]      flash_dq_o,
    output logic             flash_dq_oe_n,
    input  wire logic [15:0] flash_dq_i
);

    typedef struct packed {
        seq_state_t  st;
        logic [2:0]  op;
        logic        autoclr;
        logic        retarray;
        logic [17:0] addr;
        logic [15:0] wdata;
        logic [7:0]  fstat;
        logic [15:0] rdata;
        logic        done;
        logic        pend;
        logic        wr_pend;
        logic [7:0]  wr_ofs;
        logic [31:0] hrdata;
    } ctl_t;

    localparam ctl_t CTL_RST = '{st: S_IDLE, op: OP_READ, autoclr: 1'b0,
        retarray: 1'b0, addr: RST_ADDR, wdata: RST_DATA, fstat: RST_FSTAT,
        rdata: RST_DATA, done: 1'b0, pend: 1'b0, wr_pend: 1'b0,
        wr_ofs: 8'h00, hrdata: 32'h00000000};

    ctl_t        q;
    ctl_t        d;
    logic        cyc_start;
    logic        cyc_wr;
    logic [15:0] cyc_data;
    logic        cyc_done;
    logic [15:0] cyc_rdata;
    logic        busy;

    function automatic logic [7:0] first_code(input logic [2:0] op);
        case (op)
            OP_PROGRAM: first_code = CMD_PROG_SETUP;
            OP_ERASE:   first_code = CMD_ERASE_SETUP;
            OP_SUSPEND: first_code = CMD_SUSPEND;
            OP_RESUME:  first_code = CMD_CONFIRM;
            OP_CLEAR:   first_code = CMD_CLEAR;
            OP_RSTAT:   first_code = CMD_READ_STATUS;
            default:    first_code = CMD_READ_ARRAY;
        endcase
    endfunction

    function automatic logic [31:0] reg_read(input logic [7:0] ofs,
                                             input ctl_t s);
        case (ofs)
            OFS_CTRL:  reg_read = {26'h0, s.retarray, s.autoclr, 1'b0, s.op};
            OFS_ADDR:  reg_read = {14'h0, s.addr};
            OFS_WDATA: reg_read = {16'h0, s.wdata};
            OFS_STAT:  reg_read = {16'h0, s.fstat, 6'h0, s.done,
                                   s.st != S_IDLE};
            OFS_RDATA: reg_read = {16'h0, s.rdata};
            default:   reg_read = 32'h00000000;
        endcase
    endfunction

    assign busy = (q.st != S_IDLE);

    // pin cycle request for the current step
    always_comb begin
        cyc_wr = 1'b1;
        cyc_data = {8'h00, first_code(q.op)};
        case (q.st)
            S_CMD2:  cyc_data = (q.op == OP_PROGRAM) ? q.wdata
                                : {8'h00, CMD_CONFIRM};
            S_POLL:  cyc_wr = 1'b0;
            S_READ:  cyc_wr = 1'b0;
            S_TAIL:  cyc_data = {8'h00, CMD_CLEAR};
            S_TAIL2: cyc_data = {8'h00, CMD_READ_ARRAY};
            default: cyc_wr = 1'b1;
        endcase
    end

    assign cyc_start = busy && !q.pend;

    always_comb begin
        d = q;
        // ahb address phase
        d.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            d.wr_pend = hwrite;
            d.wr_ofs = haddr[7:0];
            if (!hwrite) begin
                d.hrdata = reg_read(haddr[7:0], q);
            end
        end
        // ahb data phase; orders are refused while an operation runs
        if (q.wr_pend && !busy) begin
            case (q.wr_ofs)
                OFS_ADDR:  d.addr = hwdata[17:0];
                OFS_WDATA: d.wdata = hwdata[15:0];
                OFS_CTRL: begin
                    d.op = hwdata[CTRL_OP_LSB +: 3];
                    d.autoclr = hwdata[CTRL_AUTOCLR];
                    d.retarray = hwdata[CTRL_RETARRAY];
                    d.done = 1'b0;
                    d.st = (hwdata[CTRL_OP_LSB +: 3] == OP_READ) ? S_READ
                                                                 : S_CMD1;
                end
                default: d.done = q.done;
            endcase
        end
        // sequencer of pin cycles
        if (cyc_start) begin
            d.pend = 1'b1;
        end
        if (cyc_done) begin
            d.pend = 1'b0;
            case (q.st)
                S_CMD1: begin
                    case (q.op)
                        OP_PROGRAM, OP_ERASE: d.st = S_CMD2;
                        OP_SUSPEND:           d.st = S_POLL;
                        OP_RSTAT, OP_RARRAY:  d.st = S_READ;
                        default: begin
                            d.st = S_IDLE;
                            d.done = 1'b1;
                        end
                    endcase
                end
                S_CMD2: d.st = S_POLL;
                S_POLL: begin
                    // each poll is a fresh oe strobe; errors kept once ready
                    if (cyc_rdata[FS_READY]) begin
                        d.fstat = cyc_rdata[7:0] & FS_MASK;
                        d.st = q.autoclr ? S_TAIL
                             : (q.retarray ? S_TAIL2 : S_IDLE);
                        d.done = !(q.autoclr || q.retarray);
                    end
                end
                S_READ: begin
                    d.rdata = cyc_rdata;
                    if (q.op == OP_RSTAT) begin
                        d.fstat = cyc_rdata[7:0] & FS_MASK;
                    end
                    d.st = S_IDLE;
                    d.done = 1'b1;
                end
                S_TAIL: begin
                    d.st = q.retarray ? S_TAIL2 : S_IDLE;
                    d.done = !q.retarray;
                end
                default: begin
                    d.st = S_IDLE;
                    d.done = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= CTL_RST;
        end else begin
            q <= d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = q.hrdata;

    // chip select returns high between cycles for standby
    flash_bus_cycle u_cycle (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .start         (cyc_start),
        .wr            (cyc_wr),
        .addr          (q.addr),
        .wdata         (cyc_data),
        .done          (cyc_done),
        .rdata         (cyc_rdata),
        .flash_ce_n    (flash_ce_n),
        .flash_oe_n    (flash_oe_n),
        .flash_we_n    (flash_we_n),
        .flash_addr    (flash_addr),
        .flash_dq_o    (flash_dq_o),
        .flash_dq_oe_n (flash_dq_oe_n),
        .flash_dq_i    (flash_dq_i)
    );

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence poll_ready;
        q.st == S_POLL && cyc_done && cyc_rdata[FS_READY];
    endsequence

    a_poll_ends_ready: assert property (
        poll_ready |=> q.st != S_POLL)
        else $error("poll continued after ready");
    a_poll_repeats: assert property (
        q.st == S_POLL && cyc_done && !cyc_rdata[FS_READY]
        |=> q.st == S_POLL && cyc_start)
        else $error("busy poll did not strobe again");
    a_status_masked: assert property (
        q.fstat[2:0] == 3'h0)
        else $error("reserved status bits kept");
    a_prog_setup: assert property (
        cyc_start && q.st == S_CMD1 && q.op == OP_PROGRAM
        |-> cyc_wr && cyc_data[7:0] == CMD_PROG_SETUP)
        else $error("program setup code wrong");
    a_erase_confirm: assert property (
        cyc_start && q.st == S_CMD2 && q.op == OP_ERASE
        |-> cyc_wr && cyc_data[7:0] == CMD_CONFIRM)
        else $error("erase confirm code wrong");
    a_busy_refuse: assert property (
        busy && q.wr_pend && q.wr_ofs == OFS_CTRL |=> $stable(q.op))
        else $error("order taken while busy");
    a_idle_ce_high: assert property (
        !busy && $past(!busy) |-> flash_ce_n)
        else $error("chip select low while idle");
    a_read_array_first: assert property (
        q.st == S_READ && q.op == OP_RARRAY && cyc_start
        |-> $past(q.st, 1) == S_READ || $past(q.st, 1) == S_CMD1)
        else $error("array read without command");
    a_done_not_busy: assert property (
        q.done |-> !busy)
        else $error("done while busy");

endmodule // flash_program_erase_status

// ---- tb.sv ----
`timescale 1ns/10ps
module tb
    import flash_ctl_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hresp;
    logic        ce_n, oe_n, we_n, dq_oe_n;
    logic [17:0] f_addr;
    logic [15:0] dq_o, dev_dq, dq_bus;
    logic        vpp_ok = 1'b1;
    logic        fail_op = 1'b0;
    logic [31:0] rd_val;
    int          n_fail = 0;
    int          checks = 0;

    always #2.5 hclk = ~hclk;
    assign dq_bus = !dq_oe_n ? dq_o : dev_dq;

    flash_program_erase_status i_flash_program_erase_status (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_addr(f_addr), .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n),
        .flash_dq_i(dq_bus));
    flash_model i_flash_model (
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr),
        .dq_in(dq_bus), .vpp_ok(vpp_ok), .fail_op(fail_op),
        .dq_out(dev_dq));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic wait_rdy();
        int n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 1000) begin
                $display("Error at %0t: bus ready timeout", $time);
                n_fail++;
                summarize();
            end
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd_val = hrdata;
    endtask
    task automatic poll();
        int n = 0;
        repeat (2) @(posedge hclk);
        do begin
            bus(1'b0, OFS_STAT, 32'h0);
            n++;
            if (n > 5000) begin
                $display("Error at %0t: status poll timeout", $time);
                n_fail++;
                summarize();
            end
        end while (rd_val[STAT_BUSY] !== 1'b0 || rd_val[STAT_DONE] !== 1'b1);
    endtask
    task automatic run_op(input logic [7:0] ctl);
        bus(1'b1, OFS_CTRL, {24'h000000, ctl});
        poll();
    endtask
    task automatic set_ad(input logic [17:0] a, input logic [15:0] d);
        bus(1'b1, OFS_ADDR, {14'h0000, a});
        bus(1'b1, OFS_WDATA, {16'h0000, d});
    endtask
    task automatic stat_is(input logic [7:0] fs);
        bus(1'b0, OFS_STAT, 32'h0);
        chk({rd_val[15:8], rd_val[1:0]}, {fs, 2'b10});
    endtask
    task automatic rdata_is(input logic [15:0] e);
        bus(1'b0, OFS_RDATA, 32'h0);
        chk(rd_val[15:0], e);
    endtask

    task automatic t_reset();
        bus(1'b0, OFS_STAT, 32'h0);
        chk(rd_val, 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd_val, 32'h0);
        chk(ce_n, 1'b1);
        chk({hready, hresp}, 2'b10);
        $display("test reset done");
    endtask
    task automatic t_program();
        set_ad(18'h00005, 16'ha5f0);
        run_op({5'h00, OP_PROGRAM});
        stat_is(8'h80);
        chk(i_flash_model.mem[5], 16'ha5f0);
        set_ad(18'h00005, 16'h0fff);
        run_op({5'h00, OP_PROGRAM});
        stat_is(8'h80);
        chk(i_flash_model.mem[5], 16'h05f0);
        run_op({5'h00, OP_READ});
        rdata_is(16'h0080);
        run_op({5'h00, OP_RARRAY});
        rdata_is(16'h05f0);
        $display("test program done");
    endtask
    task automatic t_errors();
        fail_op <= 1'b1;
        set_ad(18'h00006, 16'h1234);
        run_op({5'h00, OP_PROGRAM});
        stat_is(8'h90);
        vpp_ok <= 1'b0;
        run_op({5'h00, OP_ERASE});
        stat_is(8'hb8);
        run_op({5'h00, OP_CLEAR});
        run_op({5'h00, OP_RSTAT});
        rdata_is(16'h0080);
        set_ad(18'h00006, 16'h0000);
        run_op({5'h00, OP_PROGRAM});
        stat_is(8'h88);
        chk(i_flash_model.mem[6], 16'h1234);
        run_op({5'h00, OP_CLEAR});
        vpp_ok <= 1'b1;
        run_op({5'h00, OP_ERASE});
        stat_is(8'ha0);
        fail_op <= 1'b0;
        run_op({5'h00, OP_CLEAR});
        $display("test errors done");
    endtask
    task automatic t_erase();
        set_ad(18'h00009, 16'h0000);
        run_op({5'h00, OP_PROGRAM});
        chk(i_flash_model.mem[9], 16'h0000);
        bus(1'b1, OFS_CTRL, {29'h0, OP_ERASE});
        repeat (4) @(posedge hclk);
        bus(1'b1, OFS_ADDR, 32'h00000077);
        poll();
        stat_is(8'h80);
        chk(i_flash_model.mem[9], 16'hffff);
        bus(1'b0, OFS_ADDR, 32'h0);
        chk(rd_val[17:0], 18'h00009);
        run_op({5'h00, OP_SUSPEND});
        stat_is(8'h80);
        run_op({5'h00, OP_RESUME});
        run_op({5'h00, OP_RSTAT});
        rdata_is(16'h0080);
        run_op({5'h00, OP_READ});
        rdata_is(16'h0080);
        run_op(8'h20 | {5'h00, OP_ERASE});
        run_op({5'h00, OP_READ});
        rdata_is(16'hffff);
        $display("test erase done");
    endtask
    task automatic t_autoclr();
        fail_op <= 1'b1;
        set_ad(18'h0000a, 16'h00ff);
        run_op(8'h10 | {5'h00, OP_PROGRAM});
        stat_is(8'h90);
        fail_op <= 1'b0;
        run_op({5'h00, OP_RSTAT});
        rdata_is(16'h0080);
        $display("test autoclear done");
    endtask

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_program();
        t_errors();
        t_erase();
        t_autoclr();
        summarize();
    end
endmodule // tb
